// file: tdc_ctrl_map.svh
/*
 * Opcodes, field positions, reset values and frame counts for the arm control
 * and upstream wave ratio registers. Included by the design and the bench.
 */
`ifndef TDC_CTRL_MAP_SVH
`define TDC_CTRL_MAP_SVH

// Host opcodes
`define OP_CTRL_WR 8'hFF
`define OP_CTRL_RD 8'h7F
`define OP_WVR_RD 8'hC4

// Reset values
`define CTRL_RESET 16'h0000
`define WVR_RESET 16'h0000

// Arm control field positions
`define CTRL_ALARM_ARM_BIT 9
`define CTRL_TAMPER_ARM_BIT 8

// Frame layout in serial clock edges
`define OP_LAST_EDGE 5'h07
`define FRAME_LAST_EDGE 5'h17
`define FRAME_DONE 5'h18

// Ratio format: one integer bit, seven fraction bits
`define RATIO_LAST_STEP 3'h7
`define RATIO_SAT 8'hFF
`endif

// file: tdc_ctrl_pkg.sv
/*
 * Types shared by the arm control and wave ratio register block.
 * Assumes nothing of its surroundings; holds types only.
 */
package tdc_ctrl_pkg;
	// Ratio divider phases
	typedef enum logic [1:0] {
		DIV_IDLE,
		DIV_HI,
		DIV_LO
	} div_state_t;

	typedef logic [15:0] reg_word_t;
	typedef logic [7:0] ratio_t;
endpackage : tdc_ctrl_pkg

// file: tdc_ctrl_regs.sv
/*
 * Arm control register and upstream wave ratio result register behind a
 * four-wire serial port (mode 0, MSB first, 8-bit opcode then 16 data bits).
 * Assumes the serial clock is well below a quarter of clk_i, that rtc_match_i
 * and the clear inputs come from logic on clk_i, and that the pulse widths
 * arrive with a one-cycle widths_valid_i strobe.
 */
// Functional notes
// - The control register is written with opcode FFh, read with 7Fh, resets to 0000h and is never kept in flash.
// - Each arm bit is set in the same cycle as its matching alarm or tamper status flag.
// - Result registers are volatile, read-only to the host and never written to flash.
// - Every result register is 0000h after power-on reset.
// - Bits 15 to 8 of the wave ratio register at C4h hold the first to second pulse width ratio, weights 1 down to 1/128.
// - Bits 7 to 0 hold the second pulse width over the ideal width with the same weighting.
// - The ideal width is half the period of the upstream pulse launch frequency.
// - The alarm flag is set when the clock hours or minutes step onto the programmed alarm value.
// - The tamper status flag is set when a high level is seen on the case switch pin.
`timescale 1ns/100ps
`include "tdc_ctrl_map.svh"

module tdc_ctrl_regs (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic spi_sck_i,
	input wire logic spi_cs_n_i,
	input wire logic spi_mosi_i,
	output logic spi_miso_o,
	output logic spi_miso_oe_n_o,
	input wire logic rtc_match_i,
	input wire logic case_switch_pin_i,
	input wire logic alarm_flag_clr_i,
	input wire logic tamper_flag_clr_i,
	input wire tdc_ctrl_pkg::reg_word_t t1_width_i,
	input wire tdc_ctrl_pkg::reg_word_t t2_width_i,
	input wire tdc_ctrl_pkg::reg_word_t launch_period_i,
	input wire logic widths_valid_i,
	output logic alarm_flag_o,
	output logic tamper_status_flag_o,
	output logic alarm_arm_bit_o,
	output logic tamper_arm_bit_o
);
	import tdc_ctrl_pkg::*;

	// Pin synchronisers packed as sck, cs, mosi, case switch; stage 1 feeds stage 2 only
	logic [3:0] pin_s1_q, pin_s2_q;
	logic sck_s2_q, cs_s2_q, mosi_s2_q, csw_s2_q, sck_s3_q;
	assign {sck_s2_q, cs_s2_q, mosi_s2_q, csw_s2_q} = pin_s2_q;
	// Chip select resets high so no frame can start out of reset
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pin_s1_q <= 4'h4;
			pin_s2_q <= 4'h4;
			sck_s3_q <= 1'b0;
		end else begin
			pin_s1_q <= {spi_sck_i, spi_cs_n_i, spi_mosi_i, case_switch_pin_i};
			pin_s2_q <= pin_s1_q;
			sck_s3_q <= sck_s2_q;
		end
	end
	logic sck_rise, sck_fall;
	assign sck_rise = sck_s2_q & ~sck_s3_q;
	assign sck_fall = ~sck_s2_q & sck_s3_q;
	// Serial port state
	logic [4:0] bit_cnt_q, bit_cnt_d;
	logic [7:0] op_q, op_d;
	reg_word_t rx_q, rx_d, tx_q, tx_d;
	logic miso_q, miso_d, oe_n_q, oe_n_d;
	logic wr_commit;
	reg_word_t wr_data;
	logic alarm_flag_q, alarm_flag_d, tamper_flag_q, tamper_flag_d;
	logic alarm_arm_q, alarm_arm_d, tamper_arm_q, tamper_arm_d;
	reg_word_t wvr_q, wvr_d;
	reg_word_t ctrl_word;
	assign ctrl_word = (`CTRL_RESET | (16'h0001 << `CTRL_ALARM_ARM_BIT) & {16{alarm_arm_q}})
		| ((16'h0001 << `CTRL_TAMPER_ARM_BIT) & {16{tamper_arm_q}});
	assign wr_data = {rx_q[14:0], mosi_s2_q};
	assign wr_commit = ~cs_s2_q & sck_rise & (bit_cnt_q == `FRAME_LAST_EDGE) & (op_q == `OP_CTRL_WR);
	// Frame decode: sample on rising edge, shift out on falling edge
	always_comb begin
		bit_cnt_d = bit_cnt_q;
		op_d = op_q;
		rx_d = rx_q;
		tx_d = tx_q;
		miso_d = miso_q;
		oe_n_d = oe_n_q;
		if (cs_s2_q) begin
			bit_cnt_d = 5'h00;
			miso_d = 1'b0;
			oe_n_d = 1'b1;
		end else begin
			oe_n_d = 1'b0;
			if (sck_rise && bit_cnt_q != `FRAME_DONE) begin
				bit_cnt_d = bit_cnt_q + 5'h01;
				if (bit_cnt_q <= `OP_LAST_EDGE) begin
					op_d = {op_q[6:0], mosi_s2_q};
				end else begin
					rx_d = wr_data;
				end
				if (bit_cnt_q == `OP_LAST_EDGE) begin
					case ({op_q[6:0], mosi_s2_q})
						`OP_CTRL_RD: tx_d = ctrl_word;
						`OP_WVR_RD: tx_d = wvr_q;
						default: tx_d = 16'h0000;
					endcase
				end
			end else if (sck_fall && bit_cnt_q > `OP_LAST_EDGE) begin
				miso_d = tx_q[15];
				tx_d = {tx_q[14:0], 1'b0};
			end
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			bit_cnt_q <= 5'h00;
			op_q <= 8'h00;
			rx_q <= 16'h0000;
			tx_q <= 16'h0000;
			miso_q <= 1'b0;
			oe_n_q <= 1'b1;
		end else begin
			bit_cnt_q <= bit_cnt_d;
			op_q <= op_d;
			rx_q <= rx_d;
			tx_q <= tx_d;
			miso_q <= miso_d;
			oe_n_q <= oe_n_d;
		end
	end
	// Flags and arm bits; a set in the clearing cycle wins
	always_comb begin
		alarm_flag_d = (alarm_flag_q & ~alarm_flag_clr_i) | rtc_match_i;
		// Tamper flag on high case switch level
		tamper_flag_d = (tamper_flag_q & ~tamper_flag_clr_i) | csw_s2_q;
		alarm_arm_d = alarm_arm_q & ~(wr_commit & ~wr_data[`CTRL_ALARM_ARM_BIT]);
		tamper_arm_d = tamper_arm_q & ~(wr_commit & ~wr_data[`CTRL_TAMPER_ARM_BIT]);
		alarm_arm_d = alarm_arm_d | rtc_match_i;
		tamper_arm_d = tamper_arm_d | csw_s2_q;
	end
	// Volatile control bits reset to zero
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			alarm_flag_q <= 1'b0;
			tamper_flag_q <= 1'b0;
			alarm_arm_q <= 1'b0;
			tamper_arm_q <= 1'b0;
		end else begin
			alarm_flag_q <= alarm_flag_d;
			tamper_flag_q <= tamper_flag_d;
			alarm_arm_q <= alarm_arm_d;
			tamper_arm_q <= tamper_arm_d;
		end
	end
	// Ratio divider: long division, one quotient bit per cycle, 8 cycles per ratio
	div_state_t div_state_q, div_state_d;
	logic [2:0] step_q, step_d;
	logic [16:0] rem_q, rem_d;
	reg_word_t den_q, den_d, t2_q, t2_d, ideal_q, ideal_d;
	logic [6:0] quo_q, quo_d;
	logic sat_q, sat_d;
	ratio_t hi_q, hi_d;
	logic take;
	ratio_t ratio_out;

	assign take = rem_q >= {1'b0, den_q};
	assign ratio_out = sat_q ? `RATIO_SAT : {quo_q, take};

	always_comb begin
		div_state_d = div_state_q;
		step_d = step_q;
		rem_d = rem_q;
		den_d = den_q;
		t2_d = t2_q;
		ideal_d = ideal_q;
		quo_d = quo_q;
		sat_d = sat_q;
		hi_d = hi_q;
		wvr_d = wvr_q;
		case (div_state_q)
			DIV_IDLE: begin
				if (widths_valid_i) begin
					// Numerator t1, divisor t2; saturate when ratio reaches 2
					div_state_d = DIV_HI;
					step_d = 3'h0;
					rem_d = {1'b0, t1_width_i};
					den_d = t2_width_i;
					sat_d = (t2_width_i == 16'h0000) || ({1'b0, t1_width_i} >= {t2_width_i, 1'b0});
					t2_d = t2_width_i;
					// Ideal width is half the launch period
					ideal_d = {1'b0, launch_period_i[15:1]};
				end
			end
			DIV_HI, DIV_LO: begin
				rem_d = take ? {rem_q[15:0] - den_q, 1'b0} : {rem_q[15:0], 1'b0}; // Shifted remainder stays below twice the divisor
				quo_d = {quo_q[5:0], take};
				step_d = step_q + 3'h1;
				if (step_q == `RATIO_LAST_STEP) begin
					step_d = 3'h0;
					if (div_state_q == DIV_HI) begin
						hi_d = ratio_out;
						// Second ratio: t2 over ideal width
						div_state_d = DIV_LO;
						rem_d = {1'b0, t2_q};
						den_d = ideal_q;
						sat_d = (ideal_q == 16'h0000) || ({1'b0, t2_q} >= {ideal_q, 1'b0});
					end else begin
						wvr_d = {hi_q, ratio_out};
						div_state_d = DIV_IDLE;
					end
				end
			end
			default: div_state_d = DIV_IDLE;
		endcase
	end
	// Results clear to zero at reset
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			div_state_q <= DIV_IDLE;
			step_q <= 3'h0;
			rem_q <= 17'h0_0000;
			den_q <= 16'h0000;
			t2_q <= 16'h0000;
			ideal_q <= 16'h0000;
			quo_q <= 7'h00;
			sat_q <= 1'b0;
			hi_q <= 8'h00;
			wvr_q <= `WVR_RESET;
		end else begin
			div_state_q <= div_state_d;
			step_q <= step_d;
			rem_q <= rem_d;
			den_q <= den_d;
			t2_q <= t2_d;
			ideal_q <= ideal_d;
			quo_q <= quo_d;
			sat_q <= sat_d;
			hi_q <= hi_d;
			wvr_q <= wvr_d;
		end
	end
	assign spi_miso_o = miso_q;
	assign spi_miso_oe_n_o = oe_n_q;
	assign alarm_flag_o = alarm_flag_q;
	assign tamper_status_flag_o = tamper_flag_q;
	assign alarm_arm_bit_o = alarm_arm_q;
	assign tamper_arm_bit_o = tamper_arm_q;
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	sequence s_hi_phase;
		(div_state_q == DIV_HI) [*8];
	endsequence
	sequence s_lo_phase;
		(div_state_q == DIV_LO) [*8];
	endsequence

	property p_alarm_arm_set;
		rtc_match_i |=> alarm_arm_q && alarm_flag_q;
	endproperty
	a_alarm_arm_set: assert property (p_alarm_arm_set) else $error("alarm arm not set with flag");
	property p_tamper_arm_set;
		csw_s2_q |=> tamper_arm_q && tamper_flag_q;
	endproperty
	a_tamper_arm_set: assert property (p_tamper_arm_set) else $error("tamper arm not set with flag");
	property p_alarm_sticky;
		alarm_arm_q && !(wr_commit && !wr_data[`CTRL_ALARM_ARM_BIT]) |=> alarm_arm_q;
	endproperty
	a_alarm_sticky: assert property (p_alarm_sticky) else $error("alarm arm dropped without zero write");
	property p_tamper_sticky;
		tamper_arm_q && !(wr_commit && !wr_data[`CTRL_TAMPER_ARM_BIT]) |=> tamper_arm_q;
	endproperty
	a_tamper_sticky: assert property (p_tamper_sticky) else $error("tamper arm dropped without zero write");
	property p_one_write_inert;
		!alarm_arm_q && !rtc_match_i |=> !alarm_arm_q;
	endproperty
	a_one_write_inert: assert property (p_one_write_inert) else $error("alarm arm set by a write");
	property p_wvr_read_only;
		div_state_q != DIV_LO |=> $stable(wvr_q);
	endproperty
	a_wvr_read_only: assert property (p_wvr_read_only) else $error("wave ratio changed outside divider");
	property p_ratio_sequence;
		div_state_q == DIV_IDLE && widths_valid_i |=> s_hi_phase ##1 s_lo_phase ##1 (div_state_q == DIV_IDLE);
	endproperty
	a_ratio_sequence: assert property (p_ratio_sequence) else $error("ratio divider phase length wrong");
	property p_ctrl_read_image;
		!cs_s2_q && sck_rise && bit_cnt_q == `OP_LAST_EDGE && {op_q[6:0], mosi_s2_q} == `OP_CTRL_RD
			|=> tx_q[`CTRL_ALARM_ARM_BIT] == $past(alarm_arm_q) && tx_q[7:0] == 8'h00;
	endproperty
	a_ctrl_read_image: assert property (p_ctrl_read_image) else $error("control read image wrong");
endmodule : tdc_ctrl_regs

// file: spi_host_model.sv
/* Host serial master model for the arm control block.
   Assumes mode 0 framing and the design clock as its time base. */
`timescale 1ns/100ps
module spi_host_model (
	input wire logic clk_i,
	input wire logic spi_miso_i,
	output logic spi_sck_o,
	output logic spi_cs_n_o,
	output logic spi_mosi_o
);
	// Idle bus: deselected, clock low
	initial begin
		spi_sck_o = 1'b0;
		spi_cs_n_o = 1'b1;
		spi_mosi_o = 1'b0;
	end
	task automatic step(input int n);
		repeat (n) @(negedge clk_i);
	endtask : step
	task automatic xfer(input logic [7:0] op, input logic [15:0] wr, output logic [15:0] rd);
		logic [23:0] sh;
		sh = {op, wr};
		rd = 16'h0000;
		spi_cs_n_o = 1'b0;
		step(3);
		// Five cycle half period stays clear of the input synchronisers
		for (int i = 23; i >= 0; i--) begin
			spi_mosi_o = sh[i];
			step(5);
			if (i < 16) rd = {rd[14:0], spi_miso_i};
			spi_sck_o = 1'b1;
			step(5);
			spi_sck_o = 1'b0;
		end
		step(2);
		spi_cs_n_o = 1'b1;
		spi_mosi_o = ~spi_mosi_o; // Released line must not look held
		step(4);
	endtask : xfer
endmodule : spi_host_model

// file: tdc_ctrl_regs_tb_top.sv
/* Self-checking bench for the arm control and wave ratio registers.
   Assumes the host model drives the serial port on falling clock edges. */
`timescale 1ns/100ps
`include "tdc_ctrl_map.svh"
module tdc_ctrl_regs_tb_top;
	import tdc_ctrl_pkg::*;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic sck, cs_n, mosi, miso, miso_oe_n;
	logic rtc = 1'b0;
	logic case_switch_pin = 1'b0;
	logic aclr = 1'b0;
	logic tclr = 1'b0;
	logic valid = 1'b0;
	reg_word_t t1 = 16'h0000;
	reg_word_t t2 = 16'h0000;
	reg_word_t per = 16'h0000;
	logic af, tf, aa, ta;
	reg_word_t rd;
	int errors = 0;
	int n_checks = 0;
	// 10 MHz clock
	always #50 clk_i = ~clk_i;
	tdc_ctrl_regs u_tdc_ctrl_regs (.clk_i(clk_i), .resetn_i(resetn_i), .spi_sck_i(sck), .spi_cs_n_i(cs_n),
		.spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_n_o(miso_oe_n), .rtc_match_i(rtc),
		.case_switch_pin_i(case_switch_pin), .alarm_flag_clr_i(aclr), .tamper_flag_clr_i(tclr), .t1_width_i(t1),
		.t2_width_i(t2), .launch_period_i(per), .widths_valid_i(valid), .alarm_flag_o(af),
		.tamper_status_flag_o(tf), .alarm_arm_bit_o(aa), .tamper_arm_bit_o(ta));
	spi_host_model u_spi_host_model (.clk_i(clk_i), .spi_miso_i(miso), .spi_sck_o(sck), .spi_cs_n_o(cs_n),
		.spi_mosi_o(mosi));
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : end_of_test
	// Floor of n/d in one integer and seven fraction bits, saturating
	function automatic ratio_t ratio(input reg_word_t n, input reg_word_t d);
		logic [31:0] q;
		if (d == 16'h0000) return 8'hFF;
		q = {9'h000, n, 7'h00} / {16'h0000, d};
		return (q > 32'h0000_00FF) ? 8'hFF : q[7:0];
	endfunction : ratio
	task automatic run_ratio(input reg_word_t a, input reg_word_t b, input reg_word_t p);
		t1 = a;
		t2 = b;
		per = p;
		valid = 1'b1;
		@(negedge clk_i);
		valid = 1'b0;
		repeat (20) @(negedge clk_i);
		u_spi_host_model.xfer(`OP_WVR_RD, 16'h0000, rd);
		chk("ratio", {ratio(a, b), ratio(b, {1'b0, p[15:1]})}, rd);
	endtask : run_ratio
	// Hang guard: a run this long means a stuck wait
	initial begin
		repeat (60000) @(posedge clk_i);
		errors++;
		$display("mismatch watchdog expected finish seen hang");
		end_of_test();
	end
	// Main sequence
	initial begin
		repeat (16) @(negedge clk_i);
		resetn_i = 1'b1;
		repeat (2) @(negedge clk_i);
		chk("miso_oe_n_idle", 16'h0001, {15'h0000, miso_oe_n});
		chk("miso_idle", 16'h0000, {15'h0000, miso});
		u_spi_host_model.xfer(`OP_CTRL_RD, 16'h0000, rd);
		chk("ctrl", `CTRL_RESET, rd);
		u_spi_host_model.xfer(`OP_WVR_RD, 16'h0000, rd);
		chk("ratio", `WVR_RESET, rd);
		$display("test reset done");
		rtc = 1'b1;
		@(negedge clk_i);
		rtc = 1'b0;
		chk("alarm_flag", 16'h0001, {15'h0000, af});
		chk("alarm_arm", 16'h0001, {15'h0000, aa});
		case_switch_pin = 1'b1;
		// Arm bit must track the flag edge exactly, cycle by cycle
		for (int k = 0; k < 8; k++) begin
			@(negedge clk_i);
			chk("tamper_pair", {15'h0000, tf}, {15'h0000, ta});
		end
		chk("tamper_flag", 16'h0001, {15'h0000, tf});
		case_switch_pin = 1'b0;
		repeat (4) @(negedge clk_i);
		aclr = 1'b1;
		tclr = 1'b1;
		@(negedge clk_i);
		aclr = 1'b0;
		tclr = 1'b0;
		chk("flags", 16'h0000, {14'h0000, af, tf});
		u_spi_host_model.xfer(`OP_CTRL_WR, 16'hFFFF, rd);
		// Output enable must be driving while the frame is in progress
		fork
			u_spi_host_model.xfer(`OP_CTRL_RD, 16'h0000, rd);
			begin
				repeat (40) @(negedge clk_i);
				chk("miso_oe_n_busy", 16'h0000, {15'h0000, miso_oe_n});
			end
		join
		chk("ctrl", 16'h0300, rd);
		chk("miso_oe_n_after", 16'h0001, {15'h0000, miso_oe_n});
		u_spi_host_model.xfer(`OP_CTRL_WR, 16'h0000, rd);
		u_spi_host_model.xfer(`OP_CTRL_RD, 16'h0000, rd);
		chk("ctrl", 16'h0000, rd);
		chk("arm_pins", 16'h0000, {14'h0000, aa, ta});
		// Ones written to cleared arm bits must not set them
		u_spi_host_model.xfer(`OP_CTRL_WR, 16'hFFFF, rd);
		u_spi_host_model.xfer(`OP_CTRL_RD, 16'h0000, rd);
		chk("ctrl_one_inert", 16'h0000, rd);
		u_spi_host_model.xfer(8'h44, 16'h0000, rd);
		chk("unmapped", 16'h0000, rd);
		$display("test arm bits done");
		run_ratio(16'd100, 16'd200, 16'd400);
		run_ratio(16'd300, 16'd100, 16'h0000);
		run_ratio(16'hFFFF, 16'hFFFF, 16'h0002);
		u_spi_host_model.xfer(`OP_WVR_RD, 16'h1234, rd);
		u_spi_host_model.xfer(`OP_WVR_RD, 16'h0000, rd);
		chk("ratio_ro", {8'h80, 8'hFF}, rd);
		$display("test ratio done");
		// A second reset must clear a nonzero result word
		resetn_i = 1'b0;
		repeat (16) @(negedge clk_i);
		resetn_i = 1'b1;
		repeat (2) @(negedge clk_i);
		u_spi_host_model.xfer(`OP_WVR_RD, 16'h0000, rd);
		chk("ratio_after_reset", `WVR_RESET, rd);
		$display("test second reset done");
		end_of_test();
	end
endmodule : tdc_ctrl_regs_tb_top
